/* rtl/srm_defines.vh */
// register map, field positions and frame geometry for the path rei monitor
`ifndef SRM_DEFINES_VH
`define SRM_DEFINES_VH

// register byte addresses
`define SRM_ADDR_CTRL 16'h1183
`define SRM_ADDR_ISTAT 16'h118A
`define SRM_ADDR_CNT3 16'h119C
`define SRM_ADDR_CNT2 16'h119D
`define SRM_ADDR_CNT1 16'h119E
`define SRM_ADDR_CNT0 16'h119F

// field positions
`define SRM_CTRL_MODE_BIT 1
`define SRM_CTRL_RW_MASK 8'h0F
`define SRM_ISTAT_REI_BIT 6
`define SRM_ISTAT_CHG_MSB 5

// reset values
`define SRM_CTRL_RST 8'h00
`define SRM_ISTAT_RST 8'h00
`define SRM_CNT_RST 32'h0000_0000

// frame geometry of an sts-3 frame
`define SRM_ROWS 4'h9
`define SRM_COLS 9'h10E
`define SRM_TOH_COLS 9'h009
`define SRM_PTR_ROW 4'h3
`define SRM_H1_COL 9'h000
`define SRM_H2_COL 9'h003
`define SRM_SPE_BYTES 12'h92D
`define SRM_PTR_MAX 10'h30E
`define SRM_G1_DIST 12'h30F

// largest valid remote error value
`define SRM_REI_MAX 4'h8

`endif

/* rtl/srm_path_rei_monitor.v */
// receive sts-3c path remote error monitor with its microprocessor registers
`timescale 1ns/1ps
`include "srm_defines.vh"

// Contract
// - STS-3c mode: one concatenated SPE per frame
// - locate SPE start from H1/H2 pointer
// - REI of 1 to 8 raises interrupt, updates counter
// - drive active-low interrupt pin low
// - set status bit 6, clear on read
// - 32-bit byte-wise clear-on-read error counter
// - mode bit 1 set: add one per SPE
// - mode bit 1 clear: add REI value
// - status bits 5..0 change flags, bit7 zero
module srm_path_rei_monitor #(
  parameter CNT_W = 32
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire sts3c_mode_in,
  input wire rx_valid_in,
  input wire rx_frame_start_in,
  input wire [7:0] rx_byte_in,
  input wire [5:0] path_event_in,
  input wire [15:0] up_addr_in,
  input wire up_wr_in,
  input wire up_rd_in,
  input wire [7:0] up_wdata_in,
  output reg [7:0] up_rdata_out,
  output wire [3:0] path_ctrl_out,
  output wire rei_event_out,
  output wire int_n_out
);

  ////////////////////////////////////////////////////////////////////////
  // state
  reg [1:0] lock_st_r;
  reg [1:0] lock_st_nxt;
  reg [3:0] row_r;
  reg [8:0] col_r;
  reg [11:0] pidx_r;
  reg [7:0] h1_r;
  reg [11:0] g1_pos_r;
  reg [7:0] ctrl_r;
  reg [7:0] istat_r;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg [7:0] istat_nxt;
  reg [7:0] rd_mux;

  wire [3:0] cur_row;
  wire [8:0] cur_col;
  wire [11:0] cur_idx;
  wire in_spe;
  wire [9:0] ptr_val;
  wire [11:0] g1_calc;
  wire [3:0] rei_val;
  wire rei_hit;
  wire framed;
  wire ptr_ok;
  wire at_h1;
  wire at_h2;
  wire at_spe0;
  wire byte_ok;
  wire ptr_good;
  wire remote_error_count_mode;
  wire [3:0] clr_cnt_byte;
  wire clr_istat;

  // framing progress: hunt for a frame start, then wait for a pointer
  localparam ST_HUNT = 2'b00;
  localparam ST_FRAMED = 2'b01;
  localparam ST_LOCKED = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // wraps a payload index into one frame's worth of spe bytes
  function [11:0] spe_wrap;
    input [12:0] v;
    begin
      if (v >= {1'b0, `SRM_SPE_BYTES}) begin
        spe_wrap = v[11:0] - `SRM_SPE_BYTES;
      end else begin
        spe_wrap = v[11:0];
      end
    end
  endfunction

  // true when a read strobe hits the given byte address
  function rd_hit;
    input [15:0] addr;
    input [15:0] want;
    input rd;
    begin
      rd_hit = rd && (addr == want);
    end
  endfunction

  // true when the current byte sits in the pointer row at the given column
  function in_ptr_row;
    input [3:0] row;
    input [8:0] col;
    input [8:0] want;
    begin
      in_ptr_row = (row == `SRM_PTR_ROW) && (col == want);
    end
  endfunction

  // picks one byte lane of the error tally, lane 0 is least significant
  function [7:0] tally_lane;
    input [CNT_W-1:0] v;
    input [1:0] lane;
    begin
      tally_lane = v[8 * lane +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // frame position: a frame start byte is always row 0 col 0
  assign cur_row = rx_frame_start_in ? 4'h0 : row_r;
  assign cur_col = rx_frame_start_in ? 9'h000 : col_r;
  assign in_spe = cur_col >= `SRM_TOH_COLS;
  // pointer-row landmarks and the qualifier for a byte that moves us on
  assign at_h1 = in_ptr_row(cur_row, cur_col, `SRM_H1_COL);
  assign at_h2 = in_ptr_row(cur_row, cur_col, `SRM_H2_COL);
  assign at_spe0 = in_ptr_row(cur_row, cur_col, `SRM_TOH_COLS);
  assign byte_ok = rx_valid_in && (framed || rx_frame_start_in);
  // payload index 0 is the byte right after the last h3 byte
  assign cur_idx = at_spe0 ? 12'h000 : pidx_r;

  // pointer to the g1 byte: j1 offset is 3 bytes per pointer step
  assign ptr_val = {h1_r[1:0], rx_byte_in};
  assign g1_calc = spe_wrap({1'b0, ptr_val, 2'b00} - {3'b000, ptr_val} +
                            {1'b0, `SRM_G1_DIST});
  // a pointer beyond the last envelope offset is ignored, not trusted
  assign ptr_good = ptr_val <= `SRM_PTR_MAX;

  ////////////////////////////////////////////////////////////////////////
  // lock state: the g1 location is only trusted once a frame start and
  // then a good pointer have been seen
  assign framed = lock_st_r != ST_HUNT;
  assign ptr_ok = lock_st_r == ST_LOCKED;

  // next lock state; a later frame start re-aligns but never drops lock
  always @* begin
    lock_st_nxt = lock_st_r;
    case (lock_st_r)
      ST_HUNT: begin
        if (rx_valid_in && rx_frame_start_in) begin
          lock_st_nxt = ST_FRAMED;
        end
      end
      ST_FRAMED: begin
        if (byte_ok && at_h2 && ptr_good) begin
          lock_st_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        lock_st_nxt = ST_LOCKED;
      end
      default: begin
        lock_st_nxt = ST_HUNT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // byte position and pointer capture, advanced only on qualified bytes
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_st_r <= ST_HUNT;
      row_r <= 4'h0;
      col_r <= 9'h000;
      pidx_r <= 12'h000;
      h1_r <= 8'h00;
      g1_pos_r <= 12'h000;
    end else begin
      lock_st_r <= lock_st_nxt;
      if (byte_ok) begin
        if (cur_col == `SRM_COLS - 9'h001) begin
          col_r <= 9'h000;
          row_r <= (cur_row == `SRM_ROWS - 4'h1) ? 4'h0 : cur_row + 4'h1;
        end else begin
          col_r <= cur_col + 9'h001;
          row_r <= cur_row;
        end
        if (in_spe) begin
          pidx_r <= spe_wrap({1'b0, cur_idx} + 13'h0001);
        end
        // one pointer per frame for the single concatenated spe
        if (at_h1) begin
          h1_r <= rx_byte_in;
        end
        // out-of-range pointers keep the last good spe location
        if (at_h2 && ptr_good) begin
          g1_pos_r <= g1_calc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // remote error detection on the g1 byte
  assign rei_val = rx_byte_in[7:4];
  // values above 8 are not legal remote error counts
  assign rei_hit = rx_valid_in && framed && !rx_frame_start_in &&
                   sts3c_mode_in && ptr_ok && in_spe &&
                   cur_idx == g1_pos_r && rei_val != 4'h0 &&
                   rei_val <= `SRM_REI_MAX;
  assign rei_event_out = rei_hit;

  ////////////////////////////////////////////////////////////////////////
  // read strobes that clear one byte; there is no snapshot, so a carry
  // can slip in between two byte reads of the tally
  assign clr_cnt_byte = {rd_hit(up_addr_in, `SRM_ADDR_CNT3, up_rd_in),
                         rd_hit(up_addr_in, `SRM_ADDR_CNT2, up_rd_in),
                         rd_hit(up_addr_in, `SRM_ADDR_CNT1, up_rd_in),
                         rd_hit(up_addr_in, `SRM_ADDR_CNT0, up_rd_in)};
  assign clr_istat = rd_hit(up_addr_in, `SRM_ADDR_ISTAT, up_rd_in);

  // counting mode: 1 adds one per envelope, 0 adds the received value
  assign remote_error_count_mode = ctrl_r[`SRM_CTRL_MODE_BIT];

  // next values for status and counter: clear first, then the event
  // is added, so an event in the read cycle is never lost
  always @* begin
    cnt_nxt = cnt_r;
    if (clr_cnt_byte[3]) begin
      cnt_nxt[31:24] = 8'h00;
    end
    if (clr_cnt_byte[2]) begin
      cnt_nxt[23:16] = 8'h00;
    end
    if (clr_cnt_byte[1]) begin
      cnt_nxt[15:8] = 8'h00;
    end
    if (clr_cnt_byte[0]) begin
      cnt_nxt[7:0] = 8'h00;
    end
    if (rei_hit) begin
      if (remote_error_count_mode) begin
        cnt_nxt = cnt_nxt + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        cnt_nxt = cnt_nxt + {{(CNT_W-4){1'b0}}, rei_val};
      end
    end
    istat_nxt = istat_r;
    if (clr_istat) begin
      istat_nxt = 8'h00;
    end
    istat_nxt[`SRM_ISTAT_CHG_MSB:0] = istat_nxt[`SRM_ISTAT_CHG_MSB:0] |
                                      path_event_in;
    if (rei_hit) begin
      istat_nxt[`SRM_ISTAT_REI_BIT] = 1'b1;
    end
    istat_nxt[7] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux, sampled before this cycle's clears take effect
  always @* begin
    case (up_addr_in)
      `SRM_ADDR_CTRL: begin
        rd_mux = ctrl_r;
      end
      `SRM_ADDR_ISTAT: begin
        rd_mux = istat_r;
      end
      `SRM_ADDR_CNT3: begin
        rd_mux = tally_lane(cnt_r, 2'h3);
      end
      `SRM_ADDR_CNT2: begin
        rd_mux = tally_lane(cnt_r, 2'h2);
      end
      `SRM_ADDR_CNT1: begin
        rd_mux = tally_lane(cnt_r, 2'h1);
      end
      `SRM_ADDR_CNT0: begin
        rd_mux = tally_lane(cnt_r, 2'h0);
      end
      default: begin
        rd_mux = 8'h00; // unmapped addresses read zero
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register file
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= `SRM_CTRL_RST;
      istat_r <= `SRM_ISTAT_RST;
      cnt_r <= `SRM_CNT_RST;
      up_rdata_out <= 8'h00;
    end else begin
      istat_r <= istat_nxt;
      cnt_r <= cnt_nxt;
      if (up_wr_in && up_addr_in == `SRM_ADDR_CTRL) begin
        // upper nibble is read-only zero
        ctrl_r <= up_wdata_in & `SRM_CTRL_RW_MASK;
      end
      if (up_rd_in) begin
        up_rdata_out <= rd_mux;
      end
    end
  end

  assign path_ctrl_out = ctrl_r[3:0];
  // interrupt stays low while any status flag is pending
  assign int_n_out = ~(|istat_r);

endmodule

/* tb/srm_chk_assertions.sv */
// port checker of the path rei monitor
`timescale 1ns/1ps
module srm_chk #(
  parameter CNT_W = 32
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire sts3c_mode_in,
  input wire rx_valid_in,
  input wire rx_frame_start_in,
  input wire [7:0] rx_byte_in,
  input wire [15:0] up_addr_in,
  input wire up_wr_in,
  input wire up_rd_in,
  input wire [7:0] up_wdata_in,
  input wire [7:0] up_rdata_out,
  input wire [3:0] path_ctrl_out,
  input wire rei_event_out,
  input wire int_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // status read and control write decodes
  wire rd_st = up_rd_in && up_addr_in == 16'h118A;
  wire wr_ct = up_wr_in && up_addr_in == 16'h1183;
  ev_int_a: assert property (rei_event_out |=> !int_n_out)
    else $error("int pin not low after event");
  ev_mode_a: assert property (
    rei_event_out |-> sts3c_mode_in && rx_valid_in)
    else $error("event without mode or byte");
  ev_range_a: assert property (
    rei_event_out |-> rx_byte_in[7:4] inside {[1:8]})
    else $error("event on bad rei value");
  ev_start_a: assert property (
    rx_valid_in && rx_frame_start_in |-> !rei_event_out)
    else $error("event on frame start byte");
  ctrl_wr_a: assert property (
    wr_ct |=> ($past(up_wdata_in) & 8'h0F) == {4'h0, path_ctrl_out})
    else $error("control write lost");
  ctrl_keep_a: assert property (!wr_ct |=> $stable(path_ctrl_out))
    else $error("control changed without write");
  rd_hold_a: assert property (!up_rd_in |=> $stable(up_rdata_out))
    else $error("read data moved without read");
  st_bit7_a: assert property (rd_st |=> !up_rdata_out[7])
    else $error("status bit 7 not zero");
  int_keep_a: assert property (!int_n_out && !rd_st |=> !int_n_out)
    else $error("int released without status read");
endmodule
bind srm_path_rei_monitor srm_chk #(.CNT_W(CNT_W)) u_chk (.clk_in, .arst_n_in,
  .sts3c_mode_in, .rx_valid_in, .rx_frame_start_in, .rx_byte_in, .up_addr_in,
  .up_wr_in, .up_rd_in, .up_wdata_in, .up_rdata_out, .path_ctrl_out,
  .rei_event_out, .int_n_out);

/* tb/srm_path_rei_monitor_tb.sv */
// self-checking bench of the path rei monitor
`timescale 1ns/1ps
module srm_path_rei_monitor_tb;
  logic clk_in = 0, arst_n_in = 0, sts3c_mode_in = 1, up_wr_in = 0;
  logic up_rd_in = 0, rx_valid_in, rx_frame_start_in, rei_event_out;
  logic int_n_out, g1_now;
  logic [15:0] up_addr_in = 0;
  logic [7:0] up_wdata_in = 0, up_rdata_out, rx_byte_in, got;
  logic [5:0] path_event_in = 0;
  logic [3:0] path_ctrl_out, rei = 0;
  logic [31:0] tally;
  logic [15:0] regs [6] = '{16'h1183, 16'h118A, 16'h119C, 16'h119D,
    16'h119E, 16'h119F};
  int errors = 0, compares = 0;
  initial forever #2 clk_in = ~clk_in;
  srm_path_rei_monitor u_dut (.clk_in, .arst_n_in, .sts3c_mode_in,
    .rx_valid_in, .rx_frame_start_in, .rx_byte_in, .path_event_in,
    .up_addr_in, .up_wr_in, .up_rd_in, .up_wdata_in, .up_rdata_out,
    .path_ctrl_out, .rei_event_out, .int_n_out);
  srm_pte_model u_pte (.clk_in, .arst_n_in, .rei_in(rei),
    .valid_out(rx_valid_in), .start_out(rx_frame_start_in),
    .byte_out(rx_byte_in), .g1_now_out(g1_now));
  // compare, register access and g1 sync helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {up_addr_in, up_wdata_in, up_wr_in} = {a, d, 1'b1};
    @(negedge clk_in);
    up_wr_in = 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk_in);
    {up_addr_in, up_rd_in} = {a, 1'b1};
    @(negedge clk_in);
    up_rd_in = 0;
    got = up_rdata_out;
  endtask
  task automatic wait_g1;
    int i = 0;
    @(posedge clk_in);
    while (g1_now !== 1'b1 && i < 3000) begin
      @(posedge clk_in);
      i++;
    end
    chk(i < 3000, 1);
  endtask
  // scenarios
  task automatic t_reset;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(got, 0);
    end
    chk(int_n_out, 1);
  endtask
  // every rei code, odd codes in add-one mode, even codes in add-value mode; codes 9..15 must add nothing
  task automatic t_count;
    tally = 0;
    wr(16'h1183, 8'hFF);
    rd(16'h1183);
    chk(got, 8'h0F);
    for (int v = 0; v < 16; v++) begin
      wr(16'h1183, {6'h0, v[0], 1'b0});
      rei = 4'(v);
      if (v > 0 && v < 9) tally += v[0] ? 1 : v;
      wait_g1();
    end
    @(negedge clk_in);
    rei = 0;
    wait_g1();
    chk(int_n_out, 0);
    for (int b = 0; b < 4; b++) begin
      rd(16'h119C + b);
      chk(got, tally[31 - 8 * b -: 8]);
    end
    rd(16'h119F);
    chk(got, 0);
    rd(16'h118A);
    chk(got, 8'h40);
    chk(int_n_out, 1);
  endtask
  task automatic t_mode_off;
    sts3c_mode_in = 0;
    rei = 4'h5;
    wait_g1();
    @(negedge clk_in);
    {rei, sts3c_mode_in} = {4'h0, 1'b1};
    rd(16'h119F);
    chk(got, 0);
  endtask
  // change flags, ignored counter write, unmapped read
  task automatic t_events;
    path_event_in = 6'h3F;
    @(negedge clk_in);
    path_event_in = 0;
    @(negedge clk_in);
    chk(int_n_out, 0);
    rd(16'h118A);
    chk(got, 8'h3F);
    wr(16'h119F, 8'hFF);
    rd(16'h119F);
    chk(got, 0);
    rd(16'h1190);
    chk(got, 0);
  endtask
  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    arst_n_in = 1;
    t_reset();
    t_count();
    t_mode_off();
    t_events();
    finish_test();
  end
  // watchdog well beyond the eighteen frames the run needs
  initial begin
    #(4 * 70000);
    errors++;
    finish_test();
  end
endmodule

/* tb/srm_pte_model.sv */
// far-end model sending back-to-back sts-3 frames
`timescale 1ns/1ps
module srm_pte_model #(
  parameter int PTR = 782
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [3:0] rei_in,
  output logic valid_out,
  output logic start_out,
  output logic [7:0] byte_out,
  output logic g1_now_out
);
  localparam logic [9:0] P = PTR;
  int r, c, s;
  // row and column step on the falling edge, first valid byte is row 0 col 0
  always @(negedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= 0;
      c <= 0;
      valid_out <= 0;
    end else begin
      valid_out <= 1;
      if (valid_out) c <= (c == 269) ? 0 : c + 1;
      if (valid_out && c == 269) r <= (r == 8) ? 0 : r + 1;
    end
  end
  // one spe a frame, offsets from row 3 col 9, so g1 lands once a frame
  assign s = ((r >= 3) ? r - 3 : r + 6) * 261 + c - 9;
  assign g1_now_out = valid_out && c >= 9 && s == (PTR * 3 + 783) % 2349;
  assign start_out = r == 0 && c == 0;
  // fill bytes change every cycle so a stale read is not masked
  assign byte_out = (r == 3 && c == 0) ? {6'h18, P[9:8]} :
    (r == 3 && c == 3) ? P[7:0] :
    g1_now_out ? {rei_in, 4'hF} : 8'(c) ^ 8'hA5;
endmodule
